// ===== smc_top.sv
// Modem control, modem status, baud divisor, receiver and scratch of one serial channel
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`default_nettype none
module smc_top
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        serial_in,
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  input  wire logic        ri_n,
  input  wire logic        rlsd_n,
  input  wire logic        tx_shift_out,
  output logic             serial_out,
  output logic             dtr_n,
  output logic             rts_n,
  output logic             out1_n,
  output logic             out2_n,
  output logic             irq
);
  import smc_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] pin_s1_ff;
  logic [4:0] pin_s2_ff;
  always_ff @(posedge clk)
  begin
    pin_s1_ff <= {rlsd_n, ri_n, dsr_n, cts_n, serial_in};
    pin_s2_ff <= pin_s1_ff;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0]  mlc_ff;
  logic [7:0]  lfc_ff;
  logic [7:0]  ien_ff;
  logic [7:0]  scr_ff;
  logic [15:0] div_ff;
  logic [7:0]  rbuf_ff;
  logic        dready_ff;
  logic [3:0]  delta_ff;
  logic [3:0]  mstat_ff;
  logic        loop_on;

  // ------------------------------------------------------------
  // Write channel decode
  // ------------------------------------------------------------
  logic       aw_held_ff;
  logic       w_held_ff;
  logic [4:0] awaddr_ff;
  logic [7:0] wbyte_ff;
  logic       wbe_ff;
  logic       wr_go;
  logic       wr_known;
  logic       das;
  logic       we_data;
  logic       we_ien;
  logic       we_divl;
  logic       we_divh;
  assign das      = lfc_ff[LFC_DAS];
  assign wr_go    = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_known = (awaddr_ff == ADDR_DATA) || (awaddr_ff == ADDR_IEN)
                 || (awaddr_ff == ADDR_LFC) || (awaddr_ff == ADDR_MLC)
                 || (awaddr_ff == ADDR_LST) || (awaddr_ff == ADDR_MLS)
                 || (awaddr_ff == ADDR_SCR);
  assign we_data  = wr_go && wbe_ff && (awaddr_ff == ADDR_DATA);
  assign we_ien   = wr_go && wbe_ff && (awaddr_ff == ADDR_IEN);
  assign we_divl  = we_data && das;
  assign we_divh  = we_ien && das;

  // Address and data taken in either order, then one response
  always_ff @(posedge clk)
  begin
    // Ready again in the cycle after the held pair is answered
    s_axi_awready <= wr_go || !(aw_held_ff || (s_axi_awvalid && s_axi_awready));
    s_axi_wready  <= wr_go || !(w_held_ff || (s_axi_wvalid && s_axi_wready));
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 5'h00;
      wbyte_ff   <= 8'h00;
      wbe_ff     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= {s_axi_awaddr[4:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_ff <= 1'b1;
        wbyte_ff  <= s_axi_wdata[7:0];
        wbe_ff    <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // Control register writes
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mlc_ff <= 8'h00;
      lfc_ff <= 8'h00;
      ien_ff <= 8'h00;
      scr_ff <= 8'h00;
      div_ff <= DIV_RESET;
    end
    else if (wr_go && wbe_ff)
    begin
      if (awaddr_ff == ADDR_MLC)
        mlc_ff <= wbyte_ff & MLC_MASK;
      if (awaddr_ff == ADDR_LFC)
        lfc_ff <= wbyte_ff;
      if (awaddr_ff == ADDR_SCR)
        scr_ff <= wbyte_ff;
      if (we_ien && !das)
        ien_ff <= wbyte_ff & 8'h0f;
      if (we_divl)
        div_ff[7:0] <= wbyte_ff;
      if (we_divh)
        div_ff[15:8] <= wbyte_ff;
    end
  end

  // ------------------------------------------------------------
  // Baud generator
  // ------------------------------------------------------------
  smc_baud_if baud_bus ();
  assign baud_bus.divisor = div_ff;
  assign baud_bus.reload  = we_divl || we_divh;
  smc_baud u_baud
  (
    .clk (clk),
    .rst (rst),
    .bif (baud_bus)
  );

  // ------------------------------------------------------------
  // Loopback and modem status sources
  // ------------------------------------------------------------
  logic [3:0] mstat_now;
  logic       rx_line;
  assign loop_on   = mlc_ff[MLC_LOOP];
  // Order: cts, dsr, ri, rlsd, active high
  assign mstat_now = loop_on
                   ? {mlc_ff[MLC_OUT2], mlc_ff[MLC_OUT1], mlc_ff[MLC_DTR], mlc_ff[MLC_RTS]}
                   : ~pin_s2_ff[4:1];
  assign rx_line   = loop_on ? tx_shift_out : pin_s2_ff[0];

  // ------------------------------------------------------------
  // Receive read and status read strobes
  // ------------------------------------------------------------
  logic       rd_take;
  logic [4:0] rd_addr;
  logic       rd_rbuf;
  logic       rd_mls;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_addr = {s_axi_araddr[4:2], 2'b00};
  assign rd_rbuf = rd_take && (rd_addr == ADDR_DATA) && !das;
  assign rd_mls  = rd_take && (rd_addr == ADDR_MLS);

  // Change indicators: set wins over read clear
  logic       ring_trailing_edge_set;
  logic [3:0] delta_set;
  // Ring pin going low to high means active ring ends
  assign ring_trailing_edge_set  = mstat_ff[2] & ~mstat_now[2];
  assign delta_set = {mstat_now[3] ^ mstat_ff[3],
                      ring_trailing_edge_set,
                      mstat_now[1] ^ mstat_ff[1],
                      mstat_now[0] ^ mstat_ff[0]};
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mstat_ff <= 4'h0;
      delta_ff <= 4'h0;
    end
    else
    begin
      mstat_ff <= mstat_now;
      delta_ff <= (rd_mls ? 4'h0 : delta_ff) | delta_set;
    end
  end

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  smc_rx_state_t rx_st_ff;
  logic [3:0]    ovs_ff;
  logic [2:0]    bit_ff;
  logic [7:0]    shift_ff;
  logic [2:0]    last_bit;
  logic          tick;
  logic          mid;
  logic          rx_load;
  assign tick     = baud_bus.tick;
  assign mid      = tick && (ovs_ff == OVS_MID);
  assign last_bit = {1'b1, lfc_ff[1:0]}; // Word length 5..8
  assign rx_load  = mid && (rx_st_ff == RX_STOP);
  // Sixteen-times sampled receive state machine
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_st_ff <= RX_IDLE;
      ovs_ff   <= 4'h0;
      bit_ff   <= 3'h0;
      shift_ff <= 8'h00;
    end
    else if (tick)
    begin
      ovs_ff <= ovs_ff + 4'h1;
      case (rx_st_ff)
        RX_IDLE:
        begin
          ovs_ff <= 4'h0;
          if (!rx_line)
            rx_st_ff <= RX_START;
        end
        RX_START:
          if (mid)
          begin
            rx_st_ff <= rx_line ? RX_IDLE : RX_DATA;
            ovs_ff   <= OVS_MID + 4'h1;
            bit_ff   <= 3'h0;
            shift_ff <= 8'h00;
          end
        RX_DATA:
          if (mid)
          begin
            shift_ff[bit_ff] <= rx_line;
            bit_ff           <= bit_ff + 3'h1;
            if (bit_ff == last_bit)
              rx_st_ff <= RX_STOP;
          end
        RX_STOP:
          if (mid)
            rx_st_ff <= RX_IDLE;
        default:
          rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // Receive buffer and data ready; a new character wins over a read
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rbuf_ff   <= 8'h00;
      dready_ff <= 1'b0;
    end
    else if (rx_load)
    begin
      rbuf_ff   <= shift_ff;
      dready_ff <= 1'b1;
    end
    else if (rd_rbuf)
      dready_ff <= 1'b0;
  end

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  logic [7:0] rd_byte;
  logic       rd_known;
  assign rd_known = (rd_addr == ADDR_DATA) || (rd_addr == ADDR_IEN)
                 || (rd_addr == ADDR_LFC) || (rd_addr == ADDR_MLC)
                 || (rd_addr == ADDR_LST) || (rd_addr == ADDR_MLS)
                 || (rd_addr == ADDR_SCR);
  assign rd_byte  = (rd_addr == ADDR_DATA) ? (das ? div_ff[7:0] : rbuf_ff)
                  : (rd_addr == ADDR_IEN)  ? (das ? div_ff[15:8] : ien_ff)
                  : (rd_addr == ADDR_LFC)  ? lfc_ff
                  : (rd_addr == ADDR_MLC)  ? mlc_ff
                  : (rd_addr == ADDR_LST)  ? {7'h00, dready_ff}
                  : (rd_addr == ADDR_MLS)  ? {mstat_ff, delta_ff}
                  : (rd_addr == ADDR_SCR)  ? scr_ff
                  : 8'h00;
  always_ff @(posedge clk)
  begin
    // Address taken only while no answer is pending
    s_axi_arready <= !(rd_take || (s_axi_rvalid && !s_axi_rready));
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ------------------------------------------------------------
  // Pins and interrupt outputs
  // ------------------------------------------------------------
  logic irq_src;
  assign irq_src = (ien_ff[IEN_RDA] && dready_ff)
                || (ien_ff[IEN_MS] && (delta_ff != 4'h0));
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      serial_out <= 1'b1;
      dtr_n      <= 1'b1;
      rts_n      <= 1'b1;
      out1_n     <= 1'b1;
      out2_n     <= 1'b1;
      irq        <= 1'b0;
    end
    else
    begin
      serial_out <= loop_on ? 1'b1 : tx_shift_out;
      dtr_n      <= loop_on | ~mlc_ff[MLC_DTR];
      rts_n      <= loop_on | ~mlc_ff[MLC_RTS];
      out1_n     <= loop_on | ~mlc_ff[MLC_OUT1];
      out2_n     <= loop_on | ~mlc_ff[MLC_OUT2];
      irq        <= irq_src && mlc_ff[MLC_OUT2];
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_dtr_level: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> (dtr_n == ($past(loop_on) || !$past(mlc_ff[MLC_DTR]))))
    else $error("terminal ready pin wrong");
  a_loop_pins: assert property (@(posedge clk) disable iff (rst)
    loop_on |=> (dtr_n && rts_n && out1_n && out2_n && serial_out))
    else $error("loopback did not force outputs high");
  a_irq_gate: assert property (@(posedge clk) disable iff (rst)
    !mlc_ff[MLC_OUT2] |=> !irq)
    else $error("interrupt not gated");
  a_delta_clear: assert property (@(posedge clk) disable iff (rst)
    (rd_mls && delta_set == 4'h0 && !ring_trailing_edge_set) |=> (delta_ff == 4'h0))
    else $error("change bits not cleared by read");
  a_ring_trailing_edge_rise: assert property (@(posedge clk) disable iff (rst)
    (!mstat_ff[2] && mstat_now[2] && !delta_ff[2] && !loop_on) |=> !delta_ff[2])
    else $error("ring bit set on wrong edge");
  a_cts_change: assert property (@(posedge clk) disable iff (rst)
    (mstat_now[0] != mstat_ff[0]) |=> delta_ff[0])
    else $error("clear to send change missed");
  a_dready_load: assert property (@(posedge clk) disable iff (rst)
    rx_load |=> (dready_ff && rbuf_ff == $past(shift_ff)))
    else $error("character not loaded");
  a_mcr_upper: assert property (@(posedge clk) disable iff (rst)
    mlc_ff[7:5] == 3'h0)
    else $error("control upper bits not zero");
endmodule
`default_nettype wire

// ===== smc_pkg.sv
// Package of register map, field positions and constants for the modem channel
`default_nettype none
package smc_pkg;
  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [4:0] ADDR_DATA    = 5'h00; // Receive holding / divisor low
  localparam logic [4:0] ADDR_IEN     = 5'h04; // Interrupt enable / divisor high
  localparam logic [4:0] ADDR_LFC     = 5'h0c; // Line format control
  localparam logic [4:0] ADDR_MLC     = 5'h10; // Modem line control
  localparam logic [4:0] ADDR_LST     = 5'h14; // Line status
  localparam logic [4:0] ADDR_MLS     = 5'h18; // Modem line status
  localparam logic [4:0] ADDR_SCR     = 5'h1c; // Scratch pad
  // ------------------------------------------------------------
  // Field positions, masks and other constants
  // ------------------------------------------------------------
  localparam int MLC_DTR  = 0;
  localparam int MLC_RTS  = 1;
  localparam int MLC_OUT1 = 2;
  localparam int MLC_OUT2 = 3;
  localparam int MLC_LOOP = 4;
  localparam int LFC_DAS  = 7;
  localparam int IEN_RDA  = 0;
  localparam int IEN_MS   = 3;
  localparam logic [7:0] MLC_MASK   = 8'h1f;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  localparam logic [3:0] OVS_LAST   = 4'hf;
  localparam logic [3:0] OVS_MID    = 4'h7;
  localparam logic [1:0] RESP_OKAY  = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Receiver states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } smc_rx_state_t;
endpackage
`default_nettype wire

// ===== smc_if.sv
// Interface carrying baud divisor and tick between the top and the baud generator
`default_nettype none
interface smc_baud_if;
  logic [15:0] divisor;
  logic        reload;
  logic        tick;
  modport ctrl (output divisor, output reload, input tick);
  modport gen  (input divisor, input reload, output tick);
endinterface
`default_nettype wire

// ===== smc_baud.sv
// Baud generator producing the sixteen-times bit enable pulse
`default_nettype none
module smc_baud
(
  input  wire logic clk,
  input  wire logic rst,
  smc_baud_if.gen   bif
);
  import smc_pkg::*;
  logic [15:0] cnt_ff;
  logic        tick_ff;
  logic        at_end;
  // ------------------------------------------------------------
  // Divider: one pulse every divisor cycles, reload on latch write
  // ------------------------------------------------------------
  assign at_end   = (cnt_ff <= 16'h0001);
  assign bif.tick = tick_ff;
  always_ff @(posedge clk)
  begin
    if (rst || bif.reload)
    begin
      cnt_ff  <= (rst ? DIV_RESET : bif.divisor);
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= at_end ? bif.divisor : cnt_ff - 16'h0001;
      tick_ff <= at_end;
    end
  end
  a_tick_period: assert property (@(posedge clk) disable iff (rst)
    (!bif.reload && cnt_ff == 16'h0002) |=> ##1 (tick_ff || $past(bif.reload)))
    else $error("baud tick missed after count ran out");
endmodule
`default_nettype wire

// ===== smc_modem.sv
// Far-side model: modem lines, serial data source and transmit shift source
`default_nettype none
module smc_modem
(
  input  wire logic       clk,
  output logic      [3:0] lines_n,
  output logic            rx_line,
  output logic            tx_line
);
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------
  // Idle levels: lines inactive, serial lines marking
  // ------------------------------------------------------------
  initial
  begin
    lines_n = 4'hf;
    rx_line = 1'b1;
    tx_line = 1'b1;
  end

  // Order is rlsd, ri, dsr, cts from top bit down
  task automatic set_lines(input logic [3:0] v);
    @(posedge clk);
    lines_n <= v;
  endtask

  // Holds the receive data line at a level
  task automatic hold_rx(input logic v);
    @(posedge clk);
    rx_line <= v;
  endtask

  // One character: start bit, eight data bits lsb first, stop bit
  task automatic send(input logic on_tx, input logic [7:0] d, input int bit_cyc);
    logic [9:0] frame;
    frame = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      if (on_tx)
        tx_line <= frame[i];
      else
        rx_line <= frame[i];
      repeat (bit_cyc - 1) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ===== serial_modem_ctrl_baud_rx_tb.sv
// Self-checking bench for the modem channel: registers, modem lines, loopback, receiver
`default_nettype none
module serial_modem_ctrl_baud_rx_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import smc_pkg::*;

  logic        clk, rst;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, lines_n;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, rx_line, tx_line, serial_out;
  logic        dtr_n, rts_n, out1_n, out2_n, irq;
  int          error_cnt, compares;

  smc_top u_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .serial_in(rx_line), .cts_n(lines_n[0]),
    .dsr_n(lines_n[1]), .ri_n(lines_n[2]), .rlsd_n(lines_n[3]), .tx_shift_out(tx_line),
    .serial_out, .dtr_n, .rts_n, .out1_n, .out2_n, .irq);

  smc_modem u_modem (.clk, .lines_n, .rx_line, .tx_line);

  // ------------------------------------------------------------
  // Clock and shared tasks
  // ------------------------------------------------------------
  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic complete_run;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {4{d}};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        check(s_axi_bresp, er, "write response");
        s_axi_bready <= 1'b0;
        return;
      end
    end
    check(1'b0, 1'b1, "write hang");
    complete_run();
  endtask

  task automatic axi_rd(input logic [4:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        d = s_axi_rdata;
        check(s_axi_rresp, er, "read response");
        s_axi_rready <= 1'b0;
        return;
      end
    end
    check(1'b0, 1'b1, "read hang");
    complete_run();
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [1:0] er, input logic [7:0] exp,
                        input string what);
    logic [31:0] v;
    axi_rd(a, er, v);
    check(v, {24'h000000, exp}, what);
  endtask

  // Sends one character, waits for data ready, reads it and the flags back
  task automatic rx_frame(input logic on_tx, input logic [7:0] d);
    logic [31:0] v;
    u_modem.send(on_tx, d, 32);
    for (int n = 0; n < 40; n++)
    begin
      axi_rd(ADDR_LST, RESP_OKAY, v);
      if (v[0] === 1'b1)
        break;
    end
    check(v[0], 1'b1, "data ready set");
    check(irq, 1'b1, "data interrupt");
    rd_chk(ADDR_DATA, RESP_OKAY, d, "received char");
    axi_rd(ADDR_LST, RESP_OKAY, v);
    check(v[0], 1'b0, "data ready cleared");
    tick(3);
    check(irq, 1'b0, "data interrupt cleared");
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_scratch;
    axi_wr(ADDR_SCR, 8'ha5, RESP_OKAY);
    rd_chk(ADDR_SCR, RESP_OKAY, 8'ha5, "scratch first");
    axi_wr(ADDR_SCR, 8'h5a, RESP_OKAY);
    // Lane 0 strobe off: the byte must not land
    s_axi_wstrb <= 4'he;
    axi_wr(ADDR_SCR, 8'h33, RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    rd_chk(ADDR_MLC, RESP_OKAY, 8'h00, "control untouched");
    rd_chk(ADDR_SCR, RESP_OKAY, 8'h5a, "scratch second");
    rd_chk(5'h08, RESP_SLVERR, 8'h00, "unmapped read");
  endtask

  task automatic t_ctrl;
    for (int v = 0; v < 4; v++)
    begin
      axi_wr(ADDR_MLC, 8'(v), RESP_OKAY);
      tick(2);
      check(dtr_n, !v[0], "terminal ready pin");
      check(rts_n, !v[1], "request to send pin");
    end
    axi_wr(ADDR_MLC, 8'hff, RESP_OKAY);
    rd_chk(ADDR_MLC, RESP_OKAY, 8'h1f, "control upper bits");
    tick(2);
    check({dtr_n, rts_n, out1_n, out2_n}, 4'hf, "pins in loopback");
    axi_wr(ADDR_MLC, 8'h00, RESP_OKAY);
  endtask

  task automatic t_rx;
    axi_wr(ADDR_LFC, 8'h83, RESP_OKAY);
    axi_wr(ADDR_DATA, 8'h02, RESP_OKAY);
    axi_wr(ADDR_IEN, 8'h00, RESP_OKAY);
    rd_chk(ADDR_DATA, RESP_OKAY, 8'h02, "divisor low");
    axi_wr(ADDR_LFC, 8'h03, RESP_OKAY);
    axi_wr(ADDR_IEN, 8'h01, RESP_OKAY);
    axi_wr(ADDR_MLC, 8'h08, RESP_OKAY);
    rx_frame(1'b0, 8'h96);
    axi_wr(ADDR_MLC, 8'h18, RESP_OKAY);
    u_modem.hold_rx(1'b0);
    rx_frame(1'b1, 8'h3c);
    u_modem.hold_rx(1'b1);
    axi_wr(ADDR_MLC, 8'h08, RESP_OKAY);
  endtask

  // Steps through the modem lines; interrupt follows any change bit
  task automatic t_status;
    logic [3:0]  pin [6] = '{4'he, 4'hc, 4'h8, 4'h0, 4'h4, 4'hf};
    logic [7:0]  exp [6] = '{8'h11, 8'h32, 8'h70, 8'hf8, 8'hb4, 8'h0b};
    logic [31:0] v;
    axi_wr(ADDR_IEN, 8'h08, RESP_OKAY);
    axi_rd(ADDR_MLS, RESP_OKAY, v);
    for (int i = 0; i < 6; i++)
    begin
      u_modem.set_lines(pin[i]);
      tick(8);
      check(irq, exp[i][3:0] != 4'h0, "modem interrupt");
      rd_chk(ADDR_MLS, RESP_OKAY, exp[i], "modem status");
      tick(3);
      check(irq, 1'b0, "interrupt after read");
      rd_chk(ADDR_MLS, RESP_OKAY, {exp[i][7:4], 4'h0}, "change bits cleared");
    end
    axi_wr(ADDR_MLC, 8'h00, RESP_OKAY);
    u_modem.set_lines(4'he);
    tick(8);
    check(irq, 1'b0, "interrupt gated off");
    axi_wr(ADDR_MLC, 8'h08, RESP_OKAY);
    tick(3);
    check(irq, 1'b1, "interrupt gated on");
    rd_chk(ADDR_MLS, RESP_OKAY, 8'h11, "status before release");
    u_modem.set_lines(4'hf);
    tick(8);
    rd_chk(ADDR_MLS, RESP_OKAY, 8'h01, "status after release");
  endtask

  // Loopback: pins ignored, control bits become the status inputs
  task automatic t_loop;
    logic [7:0] mlc [3] = '{8'h15, 8'h1a, 8'h10};
    logic [7:0] exp [3] = '{8'h62, 8'h9f, 8'h09};
    axi_wr(ADDR_MLC, 8'h10, RESP_OKAY);
    u_modem.set_lines(4'h0);
    tick(8);
    rd_chk(ADDR_MLS, RESP_OKAY, 8'h00, "pins disconnected");
    for (int i = 0; i < 3; i++)
    begin
      axi_wr(ADDR_MLC, mlc[i], RESP_OKAY);
      tick(8);
      check({dtr_n, rts_n, out1_n, out2_n}, 4'hf, "pins forced high");
      check(irq, mlc[i][3], "loopback interrupt");
      rd_chk(ADDR_MLS, RESP_OKAY, exp[i], "loopback status");
    end
    u_modem.set_lines(4'hf);
    axi_wr(ADDR_MLC, 8'h00, RESP_OKAY);
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    error_cnt = 0;
    compares = 0;
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_scratch();
    t_ctrl();
    t_rx();
    t_status();
    t_loop();
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
`default_nettype wire
